// File: include/sec_pkg.sv
/*
 * constants, host command codes and frame helpers for the serial nvm controller.
 * assumes a 250 MHz system clock and a three-wire serial memory of 128 bytes.
 */
package sec_pkg;
	// ************************************************************
	// timing
	// ************************************************************
	localparam int CLK_PERIOD_NS = 4;
	localparam int SCLK_HALF_NS  = 500;                         // least half period of the serial clock
	localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TIMEOUT_MS    = 30;
	localparam int TIMEOUT_CYC   = (TIMEOUT_MS * 1000000) / CLK_PERIOD_NS;

	// ************************************************************
	// memory geometry and load sequence
	// ************************************************************
	localparam int       NVM_AW      = 7;
	localparam int       NVM_DW      = 8;
	localparam int       FRAME_W     = 18;
	localparam logic [6:0] SIG_ADDR  = 7'h00;
	localparam logic [7:0] SIG_VALUE = 8'hA5;
	localparam logic [2:0] SA_LAST   = 3'h6;                    // signature at 0, station bytes at 1..6
	localparam logic [4:0] FRAME_SHORT = 5'h0A;
	localparam logic [4:0] FRAME_LONG  = 5'h12;
	localparam logic [4:0] FRAME_TAIL  = 5'h08;                 // data bits at the end of a long frame

	// ************************************************************
	// serial opcodes
	// ************************************************************
	localparam logic [1:0] OP_MISC  = 2'h0;
	localparam logic [1:0] OP_WRITE = 2'h1;
	localparam logic [1:0] OP_READ  = 2'h2;
	localparam logic [1:0] OP_ERASE = 2'h3;
	localparam logic [1:0] SUB_DIS  = 2'h0;
	localparam logic [1:0] SUB_WALL = 2'h1;
	localparam logic [1:0] SUB_EALL = 2'h2;
	localparam logic [1:0] SUB_EN   = 2'h3;

	// ************************************************************
	// host command codes (nvm_opcode_field)
	// ************************************************************
	localparam logic [2:0] CMD_READ   = 3'h0;
	localparam logic [2:0] CMD_WDIS   = 3'h1;
	localparam logic [2:0] CMD_WEN    = 3'h2;
	localparam logic [2:0] CMD_WRITE  = 3'h3;
	localparam logic [2:0] CMD_WALL   = 3'h4;
	localparam logic [2:0] CMD_ERASE  = 3'h5;
	localparam logic [2:0] CMD_EALL   = 3'h6;
	localparam logic [2:0] CMD_RELOAD = 3'h7;

	// start bit, opcode, location, data; left justified, sent msb first
	function automatic logic [17:0] sec_frame(input logic [2:0] cmd, input logic [6:0] loc, input logic [7:0] dat);
		logic [1:0] op;
		logic [6:0] a;
		op = OP_MISC;
		a  = loc;
		case (cmd)
			CMD_READ:  op = OP_READ;
			CMD_WRITE: op = OP_WRITE;
			CMD_ERASE: op = OP_ERASE;
			CMD_WDIS:  a  = {SUB_DIS, 5'h00};
			CMD_WEN:   a  = {SUB_EN, 5'h00};
			CMD_WALL:  a  = {SUB_WALL, 5'h00};
			CMD_EALL:  a  = {SUB_EALL, 5'h00};
			default:   op = OP_READ;
		endcase
		return {1'b1, op, a, dat};
	endfunction

	// erase and write commands finish with a ready poll
	function automatic logic sec_is_pgm(input logic [2:0] cmd);
		return (cmd == CMD_WRITE) || (cmd == CMD_WALL) || (cmd == CMD_ERASE) || (cmd == CMD_EALL);
	endfunction
endpackage

// File: design/sec_shifter.sv
/*
 * bit engine: clocks one frame of 10 or 18 bits out on the serial pins.
 * assumes rx_sync is already synchronised to clk_sys; chip select is owned by the caller.
 */
`timescale 1ns/10ps
`default_nettype none
module sec_shifter
	import sec_pkg::*;
#(
	parameter int HALF_CYC = SCLK_HALF_CYC
) (
	input  wire logic        clk_sys,
	input  wire logic        rstn,
	input  wire logic        start,
	input  wire logic [17:0] frame,
	input  wire logic [4:0]  nbits,
	input  wire logic        listen,
	input  wire logic        rx_sync,
	output logic             done,
	output logic             active,
	output logic [7:0]       rx_byte,
	output logic             sclk,
	output logic             dout,
	output logic             doe
);
	typedef enum logic [1:0] {E_IDLE, E_LOW, E_HIGH} sec_eng_t;

	// ************************************************************
	// state
	// ************************************************************
	sec_eng_t    state_r;
	logic [15:0] cnt_r;
	logic [4:0]  bits_r;
	logic [17:0] sh_r;
	logic        listen_r;

	wire         half_end = (cnt_r == 16'(HALF_CYC - 1));
	wire         last_bit = (bits_r == 5'h01);
	wire         to_tail  = listen_r && (bits_r == FRAME_TAIL + 5'h01);

	assign active = (state_r != E_IDLE);

	// ************************************************************
	// one bit per serial clock: drive on the low half, sample at the end of the high half
	// ************************************************************
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			state_r  <= E_IDLE;
			cnt_r    <= 16'h0000;
			bits_r   <= 5'h00;
			sh_r     <= 18'h00000;
			listen_r <= 1'b0;
			done     <= 1'b0;
			rx_byte  <= 8'h00;
			sclk     <= 1'b0;
			dout     <= 1'b0;
			doe      <= 1'b0;
		end else begin
			done <= 1'b0;
			cnt_r <= half_end ? 16'h0000 : cnt_r + 16'h0001;
			case (state_r)
				E_IDLE: begin
					cnt_r <= 16'h0000;
					if (start) begin
						state_r  <= E_LOW;
						sh_r     <= frame;
						bits_r   <= nbits;
						listen_r <= listen;
						dout     <= frame[17]; // RULE19
						doe      <= 1'b1;
					end
				end
				E_LOW: begin
					if (half_end) begin
						sclk    <= 1'b1;
						state_r <= E_HIGH;
					end
				end
				default: begin
					if (half_end) begin
						sclk    <= 1'b0;
						rx_byte <= {rx_byte[6:0], rx_sync}; // last eight samples are the read data
						bits_r  <= bits_r - 5'h01; // RULE16
						sh_r    <= {sh_r[16:0], 1'b0};
						dout    <= sh_r[16];
						// memory drives the line once the location is in
						if (to_tail) begin
							doe <= 1'b0;
						end
						if (last_bit) begin
							state_r <= E_IDLE;
							done    <= 1'b1;
							dout    <= 1'b0;
							doe     <= 1'b0;
						end else begin
							state_r <= E_LOW;
						end
					end
				end
			endcase
		end
	end
endmodule
`default_nettype wire

// File: design/sec_controller.sv
/*
 * serial nvm controller: station address auto-load and host commands on a 128 x 8 serial memory.
 * assumes same-clock host controls and station address registers outside, one byte per strobe.
 */
//
// Contract
// RULE1 - after any reset read location 0, expect A5
// RULE2 - good signature: load six bytes into station address
// RULE3 - loaded flag only after all six bytes
// RULE4 - bad signature: stop, host writes address itself
// RULE5 - reload command repeats check and load
// RULE6 - host waits for reset-time load first
// RULE7 - host sets data before write command
// RULE8 - host sets busy, controller clears when done
// RULE9 - read data valid when busy clears
// RULE10 - host leaves command alone while busy
// RULE11 - host enables writes before erase or write
// RULE12 - no ready within 30 ms: abandon, flag timeout
// RULE13 - erase one location or erase all
// RULE14 - memory obeys write enable and disable
// RULE15 - write one location or write all
// RULE16 - 10 clocks short commands, 18 data commands
// RULE17 - interface disabled: pins become gpio or monitor
// RULE18 - memory seen as 128 bytes
// RULE19 - frame: start, opcode, location, then data
`timescale 1ns/10ps
`default_nettype none
module sec_controller
	import sec_pkg::*;
#(
	parameter int TIMEOUT_CYCLES = TIMEOUT_CYC,
	parameter int HALF_CYC       = SCLK_HALF_CYC
) (
	input  wire logic        clk_sys,
	input  wire logic        rstn,
	input  wire logic        soft_rst,
	input  wire logic        cmd_start,
	input  wire logic [2:0]  nvm_opcode_field,
	input  wire logic [6:0]  nvm_location_field,
	input  wire logic        data_wr,
	input  wire logic [7:0]  data_wdata,
	input  wire logic        nvm_if_disable,
	input  wire logic        gpio_mode,
	input  wire logic [1:0]  gpio_out,
	input  wire logic [1:0]  mii_monitor,
	input  wire logic        nvm_serial_data_pin_i,
	output logic             nvm_serial_data_pin_o,
	output logic             nvm_serial_data_pin_oe,
	output logic             nvm_serial_clock_pin,
	output logic             nvm_chip_select,
	output logic             nvm_busy_bit,
	output logic             nvm_timeout_bit,
	output logic             nvm_address_loaded_bit,
	output logic [7:0]       nvm_data_reg,
	output logic             sa_byte_we,
	output logic [2:0]       sa_byte_idx,
	output logic [7:0]       sa_byte_data
);
	typedef enum logic [2:0] {S_IDLE, S_GAP, S_RUN, S_PGM_GAP, S_POLL} sec_state_t;
	localparam int TO_W = $clog2(TIMEOUT_CYCLES + 1);

	// ************************************************************
	// data pin synchroniser
	// ************************************************************
	logic rx_meta_r;
	logic rx_sync_r;

	// the pin belongs to another party, so two flops before anything looks at it
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			rx_meta_r <= 1'b0;
			rx_sync_r <= 1'b0;
		end else begin
			rx_meta_r <= nvm_serial_data_pin_i;
			rx_sync_r <= rx_meta_r;
		end
	end

	// ************************************************************
	// control state
	// ************************************************************
	sec_state_t      state_r;
	logic            loading_r;
	logic [2:0]      idx_r;
	logic [2:0]      cmd_r;
	logic [6:0]      loc_r;
	logic            init_pend_r;
	logic [15:0]     gap_cnt_r;
	logic [TO_W-1:0] to_cnt_r;
	logic            eng_start_r;
	logic [1:0]      poll_age_r;

	logic            eng_done;
	logic            eng_active;
	logic [7:0]      eng_rx;
	logic            eng_sclk;
	logic            eng_dout;
	logic            eng_doe;

	// ************************************************************
	// request decode and frame selection
	// ************************************************************
	wire             idle        = (state_r == S_IDLE);
	wire             host_go     = idle && !init_pend_r && cmd_start && !nvm_busy_bit; // RULE8
	wire             host_reload = host_go && (nvm_opcode_field == CMD_RELOAD);
	wire             init_go     = idle && init_pend_r;
	wire             load_go     = init_go || host_reload;
	wire             gap_end     = (gap_cnt_r == 16'(HALF_CYC - 1));
	wire             timed_out   = (to_cnt_r == TO_W'(TIMEOUT_CYCLES));
	wire             sig_ok      = (eng_rx == SIG_VALUE);
	wire             sa_last     = (idx_r == SA_LAST);
	// auto-load reads locations 0..6; host reads, writes and erases use the location field
	wire [6:0]       ld_loc      = SIG_ADDR + {4'h0, idx_r}; // RULE1
	wire [17:0]      ld_frame    = sec_frame(CMD_READ, ld_loc, 8'h00);
	wire [17:0]      cmd_frame   = sec_frame(cmd_r, loc_r, nvm_data_reg);   // RULE13 RULE15
	wire             cmd_long    = (cmd_r == CMD_READ) || (cmd_r == CMD_WRITE) || (cmd_r == CMD_WALL);
	wire [17:0]      eng_frame   = loading_r ? ld_frame : cmd_frame;
	wire [4:0]       eng_nbits   = (loading_r || cmd_long) ? FRAME_LONG : FRAME_SHORT; // RULE16
	wire             eng_listen  = loading_r || (cmd_r == CMD_READ);
	wire             pgm_cmd     = sec_is_pgm(cmd_r);
	// poll line trusted only after the select round trip
	wire             poll_ready  = (state_r == S_POLL) && (poll_age_r == 2'h3) && rx_sync_r;

	// ************************************************************
	// sequencer
	// ************************************************************
	// soft reset is held pending until the sequencer is idle so a frame is never cut in half
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			init_pend_r <= 1'b1; // RULE1
		end else if (soft_rst) begin
			init_pend_r <= 1'b1;
		end else if (init_go) begin
			init_pend_r <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			state_r     <= S_IDLE;
			loading_r   <= 1'b0;
			idx_r       <= 3'h0;
			cmd_r       <= CMD_READ;
			loc_r       <= 7'h00;
			gap_cnt_r   <= 16'h0000;
			eng_start_r <= 1'b0;
			poll_age_r  <= 2'h0;
		end else begin
			eng_start_r <= 1'b0;
			gap_cnt_r   <= gap_end ? 16'h0000 : gap_cnt_r + 16'h0001;
			case (state_r)
				S_IDLE: begin
					gap_cnt_r <= 16'h0000;
					if (load_go) begin
						state_r   <= S_GAP;
						loading_r <= 1'b1;
						idx_r     <= 3'h0;
					end else if (host_go) begin
						state_r   <= S_GAP;
						loading_r <= 1'b0;
						cmd_r     <= nvm_opcode_field;
						loc_r     <= nvm_location_field; // RULE18
					end
				end
				// chip select stays low for a half period between frames
				S_GAP: begin
					if (gap_end) begin
						state_r     <= S_RUN;
						eng_start_r <= 1'b1;
					end
				end
				S_RUN: begin
					if (eng_done) begin
						if (loading_r) begin
							if ((idx_r == 3'h0) && !sig_ok) begin
								state_r   <= S_IDLE; // RULE4 RULE5
								loading_r <= 1'b0;
							end else if (sa_last) begin
								state_r   <= S_IDLE;
								loading_r <= 1'b0;
							end else begin
								state_r <= S_GAP; // RULE2
								idx_r   <= idx_r + 3'h1;
							end
						end else if (pgm_cmd) begin
							state_r <= S_PGM_GAP;
						end else begin
							state_r <= S_IDLE;
						end
					end
				end
				S_PGM_GAP: begin
					poll_age_r <= 2'h0;
					if (gap_end) begin
						state_r <= S_POLL;
					end
				end
				default: begin
					// memory raises the data line when its internal cycle ends
					if (poll_age_r != 2'h3) begin
						poll_age_r <= poll_age_r + 2'h1;
					end
					if (poll_ready || timed_out) begin
						state_r <= S_IDLE; // RULE12
					end
				end
			endcase
		end
	end

	// ************************************************************
	// timeout counter: restarts with every operation
	// ************************************************************
	// only the ready poll can stall, so the limit is checked there alone
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			to_cnt_r <= '0;
		end else if (idle) begin
			to_cnt_r <= '0;
		end else if (!timed_out) begin
			to_cnt_r <= to_cnt_r + TO_W'(1); // RULE12
		end
	end

	// ************************************************************
	// status bits and data register
	// ************************************************************
	wire sa_write   = (state_r == S_RUN) && eng_done && loading_r && (idx_r != 3'h0);
	wire load_ok    = sa_write && sa_last;
	wire poll_abort = (state_r == S_POLL) && !poll_ready && timed_out;
	wire read_done  = (state_r == S_RUN) && eng_done && !loading_r && (cmd_r == CMD_READ);
	wire op_end     = ((state_r == S_RUN) && eng_done &&
		(loading_r ? (sa_last || ((idx_r == 3'h0) && !sig_ok)) : !pgm_cmd)) ||
		((state_r == S_POLL) && (poll_ready || timed_out));

	// busy covers the reset-time load as well, so an early host start is refused
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			nvm_busy_bit           <= 1'b0;
			nvm_timeout_bit        <= 1'b0;
			nvm_address_loaded_bit <= 1'b0;
		end else begin
			if (load_go || host_go) begin
				nvm_busy_bit <= 1'b1; // RULE8 RULE6
			end else if (op_end) begin
				nvm_busy_bit <= 1'b0; // RULE8
			end
			if (poll_abort) begin
				nvm_timeout_bit <= 1'b1; // RULE12
			end else if (host_go) begin
				nvm_timeout_bit <= 1'b0;
			end
			if (load_ok) begin
				nvm_address_loaded_bit <= 1'b1; // RULE3 RULE5
			end else if (load_go) begin
				nvm_address_loaded_bit <= 1'b0;
			end
		end
	end

	// host writes to the data register are ignored while an operation runs
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			nvm_data_reg <= 8'h00;
		end else if (read_done) begin
			nvm_data_reg <= eng_rx; // RULE9
		end else if (data_wr && !nvm_busy_bit) begin
			nvm_data_reg <= data_wdata;
		end
	end

	// station address bytes go out one strobe each, byte 0 first
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			sa_byte_we   <= 1'b0;
			sa_byte_idx  <= 3'h0;
			sa_byte_data <= 8'h00;
		end else begin
			sa_byte_we <= sa_write; // RULE2
			if (sa_write) begin
				sa_byte_idx  <= idx_r - 3'h1;
				sa_byte_data <= eng_rx;
			end
		end
	end

	// ************************************************************
	// bit engine
	// ************************************************************
	sec_shifter #(
		.HALF_CYC (HALF_CYC)
	) u_shifter (
		.clk_sys  (clk_sys),
		.rstn     (rstn),
		.start    (eng_start_r),
		.frame    (eng_frame),
		.nbits    (eng_nbits),
		.listen   (eng_listen),
		.rx_sync  (rx_sync_r),
		.done     (eng_done),
		.active   (eng_active),
		.rx_byte  (eng_rx),
		.sclk     (eng_sclk),
		.dout     (eng_dout),
		.doe      (eng_doe)
	);

	// ************************************************************
	// pin multiplexing
	// ************************************************************
	wire [1:0] alt_out = gpio_mode ? gpio_out : mii_monitor;
	wire       cs_nxt  = eng_active || (state_r == S_POLL);

	// pins are registered so the memory never sees a decode glitch
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			nvm_serial_data_pin_o  <= 1'b0;
			nvm_serial_data_pin_oe <= 1'b0;
			nvm_serial_clock_pin   <= 1'b0;
			nvm_chip_select        <= 1'b0;
		end else if (nvm_if_disable) begin
			nvm_serial_data_pin_o  <= alt_out[0]; // RULE17
			nvm_serial_data_pin_oe <= 1'b1;
			nvm_serial_clock_pin   <= alt_out[1]; // RULE17
			nvm_chip_select        <= 1'b0;
		end else begin
			nvm_serial_data_pin_o  <= eng_dout;
			nvm_serial_data_pin_oe <= eng_doe;
			nvm_serial_clock_pin   <= eng_sclk;
			nvm_chip_select        <= cs_nxt;
		end
	end
endmodule
`default_nettype wire

// File: tb/sec_monitor.sv
/* checker: port relations of the serial nvm controller; bound onto it, one clock domain. */
`timescale 1ns/10ps
`default_nettype none
module sec_monitor (
	input wire logic       clk_sys,
	input wire logic       rstn,
	input wire logic       cmd_start,
	input wire logic       nvm_if_disable,
	input wire logic       gpio_mode,
	input wire logic [1:0] gpio_out,
	input wire logic [1:0] mii_monitor,
	input wire logic       nvm_serial_data_pin_o,
	input wire logic       nvm_serial_data_pin_oe,
	input wire logic       nvm_serial_clock_pin,
	input wire logic       nvm_chip_select,
	input wire logic       nvm_busy_bit,
	input wire logic       nvm_timeout_bit,
	input wire logic       nvm_address_loaded_bit,
	input wire logic       sa_byte_we,
	input wire logic [2:0] sa_byte_idx
);
	// ************
	// assertions
	// ************
	// one domain, so clock and reset are stated once
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	chk_busy_take:
		assert property (cmd_start && !nvm_busy_bit |=> nvm_busy_bit) else $error("busy missed a command");
	chk_idle_cs:
		assert property (!nvm_busy_bit |=> !nvm_chip_select) else $error("select high while idle");
	chk_sclk_frame:
		assert property (!nvm_if_disable && !$past(nvm_if_disable) && nvm_serial_clock_pin |-> nvm_chip_select)
			else $error("serial clock outside a frame");
	chk_to_ends:
		assert property ($rose(nvm_timeout_bit) |-> $fell(nvm_busy_bit)) else $error("timeout without ending");
	chk_to_holds:
		assert property (nvm_timeout_bit && !cmd_start |=> nvm_timeout_bit) else $error("timeout bit lost");
	chk_load_last:
		assert property ($rose(nvm_address_loaded_bit) |-> sa_byte_we && sa_byte_idx == 3'h5 && $fell(nvm_busy_bit))
			else $error("loaded set before last byte");
	chk_load_early:
		assert property (sa_byte_we && sa_byte_idx != 3'h5 |-> nvm_busy_bit && !nvm_address_loaded_bit)
			else $error("loaded set too early");
	chk_strobe_gap:
		assert property (sa_byte_we |=> !sa_byte_we [*8]) else $error("station strobes too close");
	chk_pin_gpio:
		assert property (nvm_if_disable && gpio_mode |=> {nvm_serial_clock_pin, nvm_serial_data_pin_o} ==
			$past(gpio_out) && nvm_serial_data_pin_oe && !nvm_chip_select) else $error("gpio pins wrong");
	chk_pin_mii:
		assert property (nvm_if_disable && !gpio_mode |=> {nvm_serial_clock_pin, nvm_serial_data_pin_o} ==
			$past(mii_monitor) && !nvm_chip_select) else $error("monitor pins wrong");
endmodule
bind sec_controller sec_monitor sec_monitor_i (.*);
`default_nettype wire

// File: tb/sec_nvm_model.sv
/* far side: 128 byte three-wire memory, write protect and ready poll; din is the resolved line. */
`timescale 1ns/10ps
`default_nettype none
module sec_nvm_model
	import sec_pkg::*;
(
	input  wire logic  cs,
	input  wire logic  sclk,
	input  wire logic  din,
	input  wire logic  stuck,
	output logic       dq,
	output logic       dq_oe,
	output logic [9:0] hdr,
	output logic [4:0] frm_n
);
	logic [7:0]  mem [128];
	logic [17:0] sh;
	logic [6:0]  a;
	logic        wen;
	logic        rd;
	int          n;
	int          st;
	// ************
	// behaviour
	// ************
	// powers up write protected
	initial begin
		{wen, rd, dq, dq_oe, hdr, frm_n, sh, a} = '0;
		n = 0;
		st = 0;
	end
	// a poll always follows, even when protection drops the store
	task automatic pgm(input logic [6:0] l, input logic [7:0] d, input logic all);
		st = 1;
		if (wen) begin
			for (int k = 0; k < 128; k++)
				if (all || k == l) mem[k] = d;
		end
	endtask
	// poll: busy low, then ready unless held stuck
	always @(posedge cs) begin
		n = 0;
		if (st == 1) begin
			st = 2;
			dq_oe = 1'b1;
			dq = 1'b0;
			#400 dq = ~stuck;
		end
	end
	// bits come in on the rising serial clock, msb first
	always @(posedge sclk) if (cs) begin
		sh = {sh[16:0], din};
		n = n + 1;
		if (n == 10) begin
			a = sh[6:0];
			rd = (sh[9:7] == {1'b1, OP_READ});
		end
	end
	// read data moves on the falling clock
	always @(negedge sclk) if (cs && rd && n < 18) begin
		dq_oe = 1'b1;
		dq = mem[a][17 - n];
	end
	// frames are judged as select drops
	always @(negedge cs) begin
		dq_oe = 1'b0;
		rd = 1'b0;
		if (st == 2)
			st = 0;
		else if (n == 10 || n == 18) begin
			frm_n = 5'(n);
			hdr = (n == 18) ? sh[17:8] : sh[9:0];
			if (hdr[9]) begin
				case (hdr[8:7])
					OP_ERASE: pgm(hdr[6:0], 8'hFF, 1'b0);
					OP_WRITE: pgm(hdr[6:0], sh[7:0], 1'b0);
					OP_MISC: begin
						if (hdr[6:5] == SUB_EN) wen = 1'b1;
						if (hdr[6:5] == SUB_DIS) wen = 1'b0;
						if (hdr[6:5] == SUB_EALL) pgm(7'h00, 8'hFF, 1'b1);
						if (hdr[6:5] == SUB_WALL) pgm(7'h00, sh[7:0], 1'b1);
					end
					default: ;
				endcase
			end
		end
	end
endmodule
`default_nettype wire

// File: tb/tb_top.sv
/* bench: host scenarios for the serial nvm controller; checker bound in, model write protected. */
`timescale 1ns/10ps
`default_nettype none
module tb_top
	import sec_pkg::*;
;
	logic       clk_sys  = 1'b0;
	logic       rstn     = 1'b0;
	logic       soft_rst = 1'b0;
	logic       cmd_start = 1'b0;
	logic [2:0] opc      = 3'h0;
	logic [6:0] loc      = 7'h00;
	logic       data_wr  = 1'b0;
	logic [7:0] wdat     = 8'h00;
	logic       if_dis   = 1'b0;
	logic       gmode    = 1'b0;
	logic [1:0] gout     = 2'h0;
	logic [1:0] mmon     = 2'h0;
	logic       stuck    = 1'b0;
	logic       tgl      = 1'b0;
	logic [7:0] sa_got [8];
	int         sa_cnt   = 0;
	int         err_total = 0;
	int         samples_checked = 0;
	wire logic  d_o, d_oe, sclk, cs, busy, tmo, lded, sa_we, m_d, m_oe, dq;
	wire logic [2:0] sa_idx;
	wire logic [7:0] sa_dat, dreg;
	wire logic [9:0] hdr;
	wire logic [4:0] frm_n;
	// ************
	// wiring
	// ************
	// a released line toggles, so a stale level is never read as data
	assign dq = d_oe ? d_o : (m_oe ? m_d : tgl);
	always #2 clk_sys = ~clk_sys;
	always @(posedge clk_sys) tgl <= ~tgl;
	always @(posedge clk_sys) if (sa_we) begin
		sa_got[sa_idx] <= sa_dat;
		sa_cnt <= sa_cnt + 1;
	end
	// short limits keep every wait brief
	sec_controller #(.TIMEOUT_CYCLES(2000), .HALF_CYC(4)) sec_controller_i (
		.clk_sys(clk_sys), .rstn(rstn), .soft_rst(soft_rst), .cmd_start(cmd_start), .nvm_opcode_field(opc),
		.nvm_location_field(loc), .data_wr(data_wr), .data_wdata(wdat), .nvm_if_disable(if_dis),
		.gpio_mode(gmode), .gpio_out(gout), .mii_monitor(mmon), .nvm_serial_data_pin_i(dq),
		.nvm_serial_data_pin_o(d_o), .nvm_serial_data_pin_oe(d_oe), .nvm_serial_clock_pin(sclk),
		.nvm_chip_select(cs), .nvm_busy_bit(busy), .nvm_timeout_bit(tmo), .nvm_address_loaded_bit(lded),
		.nvm_data_reg(dreg), .sa_byte_we(sa_we), .sa_byte_idx(sa_idx), .sa_byte_data(sa_dat));
	sec_nvm_model sec_nvm_model_i (.cs(cs), .sclk(sclk), .din(dq), .stuck(stuck), .dq(m_d), .dq_oe(m_oe),
		.hdr(hdr), .frm_n(frm_n));
	// ************
	// tasks
	// ************
	task automatic chk_v(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_b(input logic got, input logic exp);
		chk_v({15'h0000, got}, {15'h0000, exp});
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// bounded wait for busy low, then a cycle for strobes and select to settle
	task automatic wait_idle();
		int i;
		for (i = 0; i < 6000 && (i < 2 || busy !== 1'b0); i++) @(negedge clk_sys);
		@(negedge clk_sys);
		if (i == 6000) begin
			chk_b(busy, 1'b0);
			end_sim();
		end
	endtask
	// expected {length, 0, start, opcode, location}
	function automatic logic [15:0] exp_frm(input logic [2:0] c, input logic [6:0] l);
		case (c)
			CMD_READ:  return {5'h12, 4'h6, l};
			CMD_WRITE: return {5'h12, 4'h5, l};
			CMD_WALL:  return {5'h12, 4'h4, 7'h20};
			CMD_ERASE: return {5'h0A, 4'h7, l};
			CMD_EALL:  return {5'h0A, 4'h4, 7'h40};
			CMD_WEN:   return {5'h0A, 4'h4, 7'h60};
			default:   return {5'h0A, 4'h4, 7'h00};
		endcase
	endfunction
	// fields held until busy drops
	task automatic do_cmd(input logic [2:0] c, input logic [6:0] l);
		@(posedge clk_sys);
		opc <= c;
		loc <= l;
		cmd_start <= 1'b1;
		@(posedge clk_sys);
		cmd_start <= 1'b0;
		wait_idle();
		if (c != CMD_RELOAD) chk_v({frm_n, 1'b0, hdr}, exp_frm(c, l));
	endtask
	task automatic set_data(input logic [7:0] d);
		@(posedge clk_sys);
		wdat <= d;
		data_wr <= 1'b1;
		@(posedge clk_sys);
		data_wr <= 1'b0;
	endtask
	task automatic rd_chk(input logic [6:0] l, input logic [7:0] e);
		do_cmd(CMD_READ, l);
		chk_v({8'h00, dreg}, {8'h00, e});
	endtask
	task automatic load_chk(input int c0, input logic [7:0] b0, input logic [7:0] inc, input logic good);
		chk_v(16'(sa_cnt - c0), good ? 16'h0006 : 16'h0000);
		chk_b(lded, good);
		for (int k = 0; k < 6; k++)
			if (good) chk_v({8'h00, sa_got[k]}, {8'h00, b0 + inc * 8'(k)});
	endtask
	// ************
	// scenarios
	// ************
	task automatic t_protect();
		set_data(8'h5A);
		do_cmd(CMD_WRITE, 7'h20);
		rd_chk(7'h20, 8'h00);
		do_cmd(CMD_WEN, 7'h00);
		set_data(8'h5A);
		do_cmd(CMD_WRITE, 7'h20);
		rd_chk(7'h20, 8'h5A);
		do_cmd(CMD_ERASE, 7'h20);
		rd_chk(7'h20, 8'hFF);
		do_cmd(CMD_WDIS, 7'h00);
		set_data(8'h11);
		do_cmd(CMD_WRITE, 7'h20);
		rd_chk(7'h20, 8'hFF);
		$display("protect test done");
	endtask
	task automatic t_bulk();
		int c0;
		do_cmd(CMD_WEN, 7'h00);
		set_data(8'hA5);
		do_cmd(CMD_WALL, 7'h00);
		rd_chk(7'h33, 8'hA5);
		c0 = sa_cnt;
		do_cmd(CMD_RELOAD, 7'h00);
		load_chk(c0, 8'hA5, 8'h00, 1'b1);
		do_cmd(CMD_EALL, 7'h00);
		rd_chk(7'h33, 8'hFF);
		c0 = sa_cnt;
		@(posedge clk_sys);
		soft_rst <= 1'b1;
		@(posedge clk_sys);
		soft_rst <= 1'b0;
		wait_idle();
		load_chk(c0, 8'h00, 8'h00, 1'b0);
		$display("bulk and reload test done");
	endtask
	task automatic t_timeout();
		@(posedge clk_sys);
		stuck <= 1'b1;
		do_cmd(CMD_ERASE, 7'h01);
		chk_b(tmo, 1'b1);
		stuck <= 1'b0;
		do_cmd(CMD_WDIS, 7'h00);
		chk_b(tmo, 1'b0);
		$display("timeout test done");
	endtask
	task automatic t_pins();
		@(posedge clk_sys);
		if_dis <= 1'b1;
		gmode <= 1'b1;
		gout <= 2'h2;
		mmon <= 2'h1;
		repeat (2) @(negedge clk_sys);
		chk_v({12'h000, cs, d_oe, sclk, d_o}, 16'h0006);
		@(posedge clk_sys);
		gmode <= 1'b0;
		repeat (2) @(negedge clk_sys);
		chk_v({12'h000, cs, d_oe, sclk, d_o}, 16'h0005);
		@(posedge clk_sys);
		if_dis <= 1'b0;
		$display("pin mux test done");
	endtask
	// station bytes 0F+k sit behind the signature; the last location is a boundary
	initial begin
		for (int k = 0; k < 128; k++) sec_nvm_model_i.mem[k] = 8'h00;
		for (int k = 1; k < 7; k++) sec_nvm_model_i.mem[k] = 8'h0F + 8'(k);
		sec_nvm_model_i.mem[0] = 8'hA5;
		sec_nvm_model_i.mem[127] = 8'hC3;
		repeat (20) @(posedge clk_sys);
		rstn <= 1'b1;
		wait_idle();
		load_chk(0, 8'h10, 8'h01, 1'b1);
		$display("auto-load test done");
		rd_chk(7'h7F, 8'hC3);
		rd_chk(7'h03, 8'h12);
		$display("read test done");
		t_protect();
		t_bulk();
		t_timeout();
		t_pins();
		end_sim();
	end
endmodule
`default_nettype wire
